// File: pin_partner.sv
// Far-side model: open-drain reset pin with pull-up and an external driver
`timescale 1ns/1ps
`default_nettype none
module pin_partner (
    // Device side
    input  wire logic oe_n_in,
    input  wire logic drv_in,
    // Board side
    input  wire logic ext_low_in,
    output logic      pin_out
);
    // Pulled high unless a party pulls it low
    assign pin_out = ((!oe_n_in && !drv_in) || ext_low_in) ? 1'b0 : 1'b1;
endmodule
`default_nettype wire

// File: reset_source_and_stop_recovery.sv
// Reset source gathering, stop mode recovery sequencer and its register slave
// Notes on behaviour
// (R1) Reset pin lows under three clocks ignored
// (R2) Four-clock pin low always starts reset; the code ignores a pin trigger during stop mode recovery
// (R3) Stay reset while pin low; exit on release
// (R4) Pin-caused reset sets external cause flag
// (R5) Debugger request resets chip; bit self-clears
// (R6) Debugger reset sets watchdog power-on flag
// (R7) Power-on holds reset; sets power/brownout flag
// (R8) Brownout holds reset, full sequence, sets flag
// (R9) Brownout in stop: option and power bit4
// (R10) Watchdog timeout: reset if select 1, else interrupt
// (R11) Watchdog-initiated reset sets watchdog cause flag
// (R12) Reset pin is open-drain reset indicator
// (R13) Internal reset drives pin low until delay
// (R14) Stop recovery holds CPU four oscillator cycles
// (R15) Stop recovery touches only cause, oscillator registers
// (R16) Stop recovery enables and selects internal oscillator
// (R17) Leaving reset loads vector at 0002h/0003h
// (R18) Stop recovery sets stop cause flag
// (R19) Watchdog in stop: recovery, then interrupt
// (R20) Stop-enabled timer/comparator interrupt causes recovery
// (R21) Enabled GPIO level change causes recovery
// (R22) Pin or debug low in stop: system reset
// (R23) System reset holds 68 oscillator cycles
// (R24) Async sources synchronised before combining
`timescale 1ns/1ps
`default_nettype none
module reset_source_and_stop_recovery (
    // Clock and reset
    input  wire logic             core_clk_in,
    input  wire logic             rstn_in,
    // Register bus
    input  wire rst_pkg::wb_req_t wb_in,
    output logic                  wb_ack_out,
    output logic [31:0]           wb_dat_out,
    // Asynchronous sources
    input  wire logic             rst_pin_in,
    output logic                  rst_pin_out,
    output logic                  rst_pin_oe_n_out,
    input  wire logic             debug_pin_in,
    input  wire logic             por_n_in,
    input  wire logic             brownout_detect_in,
    input  wire logic             lvd_in,
    input  wire logic [7:0]       gpio_in,
    // Core-side events and options
    input  wire logic             stop_req_in,
    input  wire logic             watchdog_timer_to_in,
    input  wire logic             timer_stop_irq_in,
    input  wire logic             comp_stop_irq_in,
    input  wire logic             watchdog_reset_select_in,
    input  wire logic             brownout_always_on_in,
    // Reset and clock control outputs
    output logic                  sys_reset_out,
    output logic                  cpu_reset_out,
    output logic                  stop_mode_out,
    output logic                  brownout_active_out,
    output logic                  watchdog_irq_out,
    output logic                  vec_load_out,
    output logic [15:0]           vec_addr_out,
    output logic                  ipo_enable_out,
    output logic                  ipo_select_out
);
    rst_pkg::seq_state_t st_q, st_d;

    logic [rst_pkg::SYNC_W-1:0] sa_q, sb_q, sc_q, ag_q;
    logic [7:0] gpio_prev_q;
    logic [1:0] lo_cnt_q;
    logic [6:0] cnt_q;
    logic [1:0] div_q;
    logic       smr_q, irq_pend_q;
    logic [7:0] cause_q, cause_d, pwr_q, wake_q, osc_q;
    logic       dbg_req_q, wdc_por_q;
    logic       ack_q;
    logic [31:0] rdat_q;

    logic pin_lo, por_hold, bo_hold, ext_trig, gpio_chg, tick, done;
    logic ev_por, ev_ext, ev_dbg, ev_wrst, ev_smr, ev_smr_wdt, ev_smr_gpio;
    logic wr, rd, sys_d;

    function automatic logic hit(input logic [7:0] adr, input logic [7:0] ofs);
        hit = (adr[7:2] == ofs[7:2]);
    endfunction

    // Three-stage synchronisers; a change counts once stages two and three agree
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            sa_q <= rst_pkg::SYNC_RST;
            sb_q <= rst_pkg::SYNC_RST;
            sc_q <= rst_pkg::SYNC_RST;
            ag_q <= rst_pkg::SYNC_RST;
        end else begin
            sa_q <= {lvd_in, brownout_detect_in, por_n_in, debug_pin_in, rst_pin_in, gpio_in}; // [R24]
            sb_q <= sa_q;
            sc_q <= sb_q;
            ag_q <= (sb_q & ~(sb_q ^ sc_q)) | (ag_q & (sb_q ^ sc_q)); // [R24]
        end
    end

    assign pin_lo   = !ag_q[rst_pkg::S_RSTPIN];
    assign bo_hold  = ag_q[rst_pkg::S_BOLOW] && brownout_active_out; // [R8]
    assign por_hold = !ag_q[rst_pkg::S_POR_N] || bo_hold; // [R7] [R8]
    assign gpio_chg = |((ag_q[7:0] ^ gpio_prev_q) & wake_q); // [R21]

    // Brownout runs in stop only with the option set and power bit 4 clear
    assign brownout_active_out = (st_q != rst_pkg::ST_STOP) ||
                                 (brownout_always_on_in && !pwr_q[rst_pkg::PWR_BO_OFF]); // [R9]

    // Reset pin low-width filter
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            lo_cnt_q    <= 2'h0;
            gpio_prev_q <= 8'h00;
        end else begin
            gpio_prev_q <= ag_q[7:0];
            if (!pin_lo) begin
                lo_cnt_q <= 2'h0;
            end else if (lo_cnt_q != rst_pkg::PIN_MIN_LOW) begin
                lo_cnt_q <= lo_cnt_q + 2'h1;
            end
        end
    end

    // Third consecutive low sample triggers
    assign ext_trig = pin_lo && (lo_cnt_q == 2'h2); // [R1] [R2]

    assign tick = (div_q == rst_pkg::IPO_DIV_LAST);
    assign done = (cnt_q == rst_pkg::SYS_HOLD_IPO);

    // Sequencer next state and trigger decode
    always_comb begin
        st_d        = st_q;
        ev_por      = 1'b0;
        ev_ext      = 1'b0;
        ev_dbg      = 1'b0;
        ev_wrst     = 1'b0;
        ev_smr      = 1'b0;
        ev_smr_wdt  = 1'b0;
        ev_smr_gpio = 1'b0;
        unique case (st_q)
            rst_pkg::ST_RUN: begin
                if (por_hold) begin
                    ev_por = 1'b1; // [R7] [R8]
                end else if (ext_trig) begin
                    ev_ext = 1'b1; // [R4]
                end else if (dbg_req_q) begin
                    ev_dbg = 1'b1; // [R5]
                end else if (watchdog_timer_to_in && watchdog_reset_select_in) begin
                    ev_wrst = 1'b1; // [R10] [R11]
                end else if (stop_req_in) begin
                    st_d = rst_pkg::ST_STOP;
                end
            end
            rst_pkg::ST_STOP: begin
                if (por_hold) begin
                    ev_por = 1'b1;
                end else if (ext_trig || !ag_q[rst_pkg::S_DBGPIN]) begin
                    ev_ext = ext_trig; // [R22]
                    ev_dbg = !ext_trig; // [R22]
                end else if (watchdog_timer_to_in) begin
                    ev_smr_wdt = 1'b1; // [R19]
                end else if (timer_stop_irq_in || comp_stop_irq_in) begin
                    ev_smr = 1'b1; // [R20]
                end else if (gpio_chg) begin
                    ev_smr_gpio = 1'b1; // [R21]
                end
            end
            rst_pkg::ST_START: begin
                if (por_hold) begin
                    st_d = rst_pkg::ST_SYS;
                end else if (cnt_q == rst_pkg::START_LAST) begin
                    st_d = smr_q ? rst_pkg::ST_SMR : rst_pkg::ST_SYS;
                end
            end
            rst_pkg::ST_SYS: begin
                if (done && !pin_lo && !por_hold) begin
                    st_d = rst_pkg::ST_RUN; // [R3] [R23]
                end
            end
            rst_pkg::ST_SMR: begin
                if (tick && cnt_q == rst_pkg::SMR_HOLD_IPO - 7'h1) begin
                    st_d = rst_pkg::ST_RUN; // [R14]
                end
            end
        endcase
        if (ev_por || ev_ext || ev_dbg || ev_wrst || ev_smr || ev_smr_wdt || ev_smr_gpio) begin
            st_d = rst_pkg::ST_START;
        end
    end

    assign sys_d = (st_d == rst_pkg::ST_SYS) ||
                   (st_d == rst_pkg::ST_START && !(ev_smr || ev_smr_wdt || ev_smr_gpio) &&
                    !(st_q == rst_pkg::ST_START && smr_q));

    // Sequencer state, type flag and oscillator-cycle counting
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            st_q  <= rst_pkg::ST_START;
            smr_q <= 1'b0;
            cnt_q <= 7'h00;
            div_q <= 2'h0;
        end else begin
            st_q <= st_d;
            if (st_q != rst_pkg::ST_START) begin
                smr_q <= ev_smr || ev_smr_wdt || ev_smr_gpio;
            end
            if (st_d != st_q) begin
                cnt_q <= 7'h00;
                div_q <= 2'h0;
            end else if (st_q == rst_pkg::ST_START) begin
                cnt_q <= cnt_q + 7'h01;
            end else if (st_q == rst_pkg::ST_SYS && por_hold) begin
                cnt_q <= 7'h00; // [R8]
                div_q <= 2'h0;
            end else begin
                div_q <= tick ? 2'h0 : div_q + 2'h1;
                if (tick && !done) begin
                    cnt_q <= cnt_q + 7'h01; // [R23]
                end
            end
        end
    end

    // Reset outputs and open-drain indicator
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            sys_reset_out    <= 1'b1;
            cpu_reset_out    <= 1'b1;
            stop_mode_out    <= 1'b0;
            rst_pin_oe_n_out <= 1'b0;
            vec_load_out     <= 1'b0;
        end else begin
            sys_reset_out <= sys_d;
            cpu_reset_out <= (st_d != rst_pkg::ST_RUN) && (st_d != rst_pkg::ST_STOP); // [R14]
            stop_mode_out <= (st_d == rst_pkg::ST_STOP);
            // Drive low through the delay, then release so the pin can rise
            rst_pin_oe_n_out <= !((sys_d && !(st_d == rst_pkg::ST_SYS && st_q == rst_pkg::ST_SYS &&
                                              done && !por_hold)) ||
                                  (pwr_q[rst_pkg::PWR_IND] && st_d == rst_pkg::ST_SMR)); // [R12] [R13]
            vec_load_out <= (st_d == rst_pkg::ST_RUN) &&
                            (st_q == rst_pkg::ST_SYS || st_q == rst_pkg::ST_SMR); // [R17]
        end
    end

    assign rst_pin_out  = 1'b0;
    assign vec_addr_out = rst_pkg::VEC_ADDR; // [R17]

    // Watchdog interrupt: immediate in run, deferred past recovery in stop
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            watchdog_irq_out <= 1'b0;
            irq_pend_q       <= 1'b0;
        end else begin
            watchdog_irq_out <= 1'b0;
            if (st_q == rst_pkg::ST_RUN && watchdog_timer_to_in &&
                !watchdog_reset_select_in && !por_hold && !ext_trig && !dbg_req_q) begin
                watchdog_irq_out <= 1'b1; // [R10]
            end
            if (ev_smr_wdt && !watchdog_reset_select_in) begin
                irq_pend_q <= 1'b1; // [R19]
            end else if (sys_d) begin
                irq_pend_q <= 1'b0;
            end else if (irq_pend_q && st_q == rst_pkg::ST_SMR && st_d == rst_pkg::ST_RUN) begin
                irq_pend_q       <= 1'b0;
                watchdog_irq_out <= 1'b1; // [R19]
            end
        end
    end

    // Bus decode
    assign wr = wb_in.cyc && wb_in.stb && wb_in.we && !ack_q && wb_in.sel[0];
    assign rd = wb_in.cyc && wb_in.stb && !wb_in.we && !ack_q;

    // Cause flags; event sets win over the read clear
    always_comb begin
        cause_d = cause_q;
        if (rd && hit(wb_in.adr, rst_pkg::CAUSE_OFS)) begin
            cause_d[7:4] = 4'h0;
        end
        if (ev_por) begin
            cause_d[7:4] = 4'h8; // [R7] [R8]
        end
        if (ev_ext) begin
            cause_d[rst_pkg::CAUSE_EXT] = 1'b1; // [R4]
        end
        if (ev_wrst) begin
            cause_d[rst_pkg::CAUSE_POB]  = 1'b0;
            cause_d[rst_pkg::CAUSE_STOP] = 1'b0;
            cause_d[rst_pkg::CAUSE_WDT]  = 1'b1; // [R11]
        end
        if (ev_smr || ev_smr_wdt || ev_smr_gpio) begin
            cause_d[rst_pkg::CAUSE_POB]  = 1'b0;
            cause_d[rst_pkg::CAUSE_STOP] = 1'b1; // [R18]
        end
        if (ev_smr_wdt) begin
            cause_d[rst_pkg::CAUSE_WDT] = 1'b1; // [R19]
        end
        if (ev_smr_gpio) begin
            cause_d[rst_pkg::CAUSE_WDT] = 1'b0;
            cause_d[rst_pkg::CAUSE_EXT] = 1'b0;
        end
        cause_d[3:1]               = 3'h0;
        cause_d[rst_pkg::CAUSE_LVD] = ag_q[rst_pkg::S_LVD];
    end

    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            cause_q <= rst_pkg::CAUSE_RST;
        end else begin
            cause_q <= cause_d;
        end
    end

    // Registers cleared by system reset only; recovery leaves them alone
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in || sys_reset_out) begin
            pwr_q  <= rst_pkg::PWR_RST; // [R15]
            wake_q <= rst_pkg::WAKE_RST;
        end else if (wr && hit(wb_in.adr, rst_pkg::PWR_OFS)) begin
            pwr_q <= wb_in.dat[7:0];
        end else if (wr && hit(wb_in.adr, rst_pkg::WAKE_OFS)) begin
            wake_q <= wb_in.dat[7:0];
        end
    end

    // Oscillator control: recovery forces the internal oscillator on and selected
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in || sys_reset_out || st_q == rst_pkg::ST_SMR) begin
            osc_q <= rst_pkg::OSC_RST; // [R16]
        end else if (wr && hit(wb_in.adr, rst_pkg::OSC_OFS)) begin
            osc_q <= wb_in.dat[7:0];
        end
    end

    assign ipo_enable_out = osc_q[rst_pkg::OSC_EN];
    assign ipo_select_out = osc_q[rst_pkg::OSC_SEL];

    // Debugger request clears on any system reset; the power-on flag survives system reset
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            dbg_req_q <= 1'b0;
            wdc_por_q <= 1'b0;
        end else begin
            if (sys_reset_out) begin
                dbg_req_q <= 1'b0; // [R5]
            end else if (wr && hit(wb_in.adr, rst_pkg::DBGC_OFS)) begin
                dbg_req_q <= wb_in.dat[rst_pkg::DBGC_REQ];
            end
            if (ev_dbg || ev_por) begin
                wdc_por_q <= 1'b1; // [R6]
            end else if (wr && hit(wb_in.adr, rst_pkg::WDC_OFS) && wb_in.dat[rst_pkg::WDC_POR]) begin
                wdc_por_q <= 1'b0;
            end
        end
    end

    // Wishbone answer: one wait state, unmapped reads return zero
    always_ff @(posedge core_clk_in) begin
        if (!rstn_in) begin
            ack_q  <= 1'b0;
            rdat_q <= 32'h00000000;
        end else begin
            ack_q  <= wb_in.cyc && wb_in.stb && !ack_q;
            rdat_q <= 32'h00000000;
            if (rd) begin
                unique case (1'b1)
                    hit(wb_in.adr, rst_pkg::CAUSE_OFS): rdat_q[7:0] <= cause_q;
                    hit(wb_in.adr, rst_pkg::PWR_OFS):   rdat_q[7:0] <= pwr_q;
                    hit(wb_in.adr, rst_pkg::DBGC_OFS):  rdat_q[0]   <= dbg_req_q;
                    hit(wb_in.adr, rst_pkg::WDC_OFS):   rdat_q[7]   <= wdc_por_q;
                    hit(wb_in.adr, rst_pkg::OSC_OFS):   rdat_q[7:0] <= osc_q;
                    hit(wb_in.adr, rst_pkg::WAKE_OFS):  rdat_q[7:0] <= wake_q;
                    default:                           rdat_q      <= 32'h00000000;
                endcase
            end
        end
    end

    assign wb_ack_out = ack_q;
    assign wb_dat_out = rdat_q;

    AST_SHORT_PULSE: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [R1]
        ext_trig |-> pin_lo && $past(pin_lo) && $past(pin_lo, 2))
        else $error("pin trigger without three low samples");
    AST_FOUR_CLK: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [R2]
        (st_q == rst_pkg::ST_RUN && !por_hold && ext_trig) |=> st_q == rst_pkg::ST_START && sys_reset_out)
        else $error("agreed low pin did not start system reset");
    AST_HOLD_PIN: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [R3]
        (st_q == rst_pkg::ST_SYS && pin_lo) |=> st_q == rst_pkg::ST_SYS)
        else $error("left reset while pin low");
    AST_EXT_FLAG: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [R4]
        ev_ext |=> cause_q[rst_pkg::CAUSE_EXT])
        else $error("external cause flag not set");
    AST_DBG_RST: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [R5]
        ev_dbg |=> ##[1:2] !dbg_req_q && sys_reset_out)
        else $error("debugger request did not reset and clear");
    AST_WDC_POR: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [R6]
        ev_dbg |=> wdc_por_q)
        else $error("power-on flag not set after debugger reset");
    AST_WDT_IRQ: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [R10]
        (st_q == rst_pkg::ST_RUN && watchdog_timer_to_in && !watchdog_reset_select_in && !por_hold &&
         !ext_trig && !dbg_req_q) |=> watchdog_irq_out && !sys_reset_out)
        else $error("watchdog interrupt mode misbehaved");
    AST_PIN_DRIVE: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [R13]
        (st_q == rst_pkg::ST_SYS && !done) |-> !rst_pin_oe_n_out)
        else $error("reset pin not driven during delay");
    AST_SMR_LEN: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [R14]
        $rose(st_q == rst_pkg::ST_SMR) |-> (st_q == rst_pkg::ST_SMR)[*8] ##1 st_q == rst_pkg::ST_RUN)
        else $error("recovery hold not four oscillator cycles");
    AST_OSC_SMR: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [R16]
        $fell(st_q == rst_pkg::ST_SMR) |-> ipo_enable_out && ipo_select_out)
        else $error("oscillator not restored after recovery");
    AST_STOP_FLAG: assert property (@(posedge core_clk_in) disable iff (!rstn_in) // [R18]
        (ev_smr || ev_smr_gpio || ev_smr_wdt) |=> cause_q[rst_pkg::CAUSE_STOP] && !cause_q[rst_pkg::CAUSE_POB])
        else $error("stop cause flag not set");
endmodule
`default_nettype wire

// File: reset_source_and_stop_recovery_test.sv
// Self-checking bench for the reset and stop recovery controller
`timescale 1ns/1ps
`default_nettype none
module reset_source_and_stop_recovery_test;
    logic             clk = 1'b0;
    logic             rstn = 1'b0;
    rst_pkg::wb_req_t wb = '0;
    logic             ext_low = 1'b0, dbg = 1'b1, wdt_to = 1'b0, wsel = 1'b1, stp = 1'b0, tirq = 1'b0;
    logic [7:0]       gpio = 8'h00, mask;
    logic             ack, sysr, cpur, stopm, boa, irq, vecl, ipoe, ipos, oe_n, pdo, pin;
    logic [31:0]      rdat, q;
    logic [15:0]      vaddr;
    logic [31:0]      seed = 32'h4513B785;
    int               bad_count = 0, tests_run = 0, cyc = 0, exp_cause;

    always #25 clk = ~clk;

    reset_source_and_stop_recovery dut (.core_clk_in(clk), .rstn_in(rstn), .wb_in(wb), .wb_ack_out(ack),
        .wb_dat_out(rdat), .rst_pin_in(pin), .rst_pin_out(pdo), .rst_pin_oe_n_out(oe_n), .debug_pin_in(dbg),
        .por_n_in(1'b1), .brownout_detect_in(1'b0), .lvd_in(1'b0), .gpio_in(gpio), .stop_req_in(stp),
        .watchdog_timer_to_in(wdt_to), .timer_stop_irq_in(tirq), .comp_stop_irq_in(1'b0),
        .watchdog_reset_select_in(wsel), .brownout_always_on_in(1'b1), .sys_reset_out(sysr),
        .cpu_reset_out(cpur), .stop_mode_out(stopm), .brownout_active_out(boa), .watchdog_irq_out(irq),
        .vec_load_out(vecl), .vec_addr_out(vaddr), .ipo_enable_out(ipoe), .ipo_select_out(ipos));

    pin_partner far (.oe_n_in(oe_n), .drv_in(pdo), .ext_low_in(ext_low), .pin_out(pin));

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count = bad_count + 1;
            print_verdict();
        end
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run = tests_run + 1;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            bad_count = bad_count + 1;
        end
    endtask

    // One classic cycle; answer taken at the edge that samples ack
    task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        @(posedge clk);
        wb <= '{cyc: 1'b1, stb: 1'b1, we: we, sel: 4'hF, adr: a, dat: d};
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        r = rdat;
        wb <= '0;
    endtask

    // Wait for cpu (s=0) or system (s=1) reset to reach level v
    task automatic wait_sig(input int s, input logic v, input int lim);
        int n;
        n = 0;
        while (((s == 1) ? sysr : cpur) !== v && n < lim) begin
            @(posedge clk);
            n = n + 1;
        end
        chk("reset wait", 32'(v), 32'((s == 1) ? sysr : cpur));
    endtask

    // Stimulus lines: 0 pin low, 1 watchdog, 2 stop, 3 debug pin low, 4 timer wake
    task automatic drive(input int s, input logic on);
        case (s)
            0: ext_low <= on;
            1: wdt_to <= on;
            2: stp <= on;
            3: dbg <= !on;
            default: tirq <= on;
        endcase
    endtask

    task automatic pulse(input int s, input int n);
        @(posedge clk);
        drive(s, 1'b1);
        repeat (n) @(posedge clk);
        drive(s, 1'b0);
    endtask

    initial begin
        repeat (3) @(posedge clk);
        rstn <= 1'b1;
        wait_sig(0, 1'b0, 1000);
        chk("vec_load", 32'h1, 32'(vecl));
        chk("vec_addr", 32'h0002, 32'(vaddr));
        bus(1'b0, rst_pkg::CAUSE_OFS, 32'h0, q);
        chk("cause por", 32'h80, q);
        $display("power-on test done");
        pulse(0, 2);
        repeat (12) @(posedge clk);
        chk("short pin", 32'h0, 32'(sysr));
        pulse(0, 4);
        wait_sig(1, 1'b1, 20);
        repeat (2) @(posedge clk);
        chk("pin drive", 32'h0, 32'(oe_n));
        wait_sig(0, 1'b0, 1000);
        bus(1'b0, rst_pkg::CAUSE_OFS, 32'h0, q);
        chk("cause ext", 32'h10, q);
        $display("pin test done");
        wsel <= 1'b0;
        pulse(1, 1);
        @(posedge clk);
        chk("wdt irq", 32'h1, 32'(irq));
        wsel <= 1'b1;
        pulse(1, 1);
        wait_sig(1, 1'b1, 10);
        wait_sig(0, 1'b0, 1000);
        exp_cause = 1 << rst_pkg::CAUSE_WDT;
        bus(1'b0, rst_pkg::CAUSE_OFS, 32'h0, q);
        chk("cause wdt", 32'(exp_cause), q);
        $display("watchdog test done");
        bus(1'b1, rst_pkg::DBGC_OFS, 32'h1, q);
        wait_sig(1, 1'b1, 20);
        wait_sig(0, 1'b0, 1000);
        bus(1'b0, rst_pkg::DBGC_OFS, 32'h0, q);
        chk("debug req clear", 32'h0, q);
        bus(1'b0, rst_pkg::WDC_OFS, 32'h0, q);
        chk("wdc por flag", 32'h80, q);
        $display("debugger test done");
        seed = xs(seed);
        mask = seed[7:0] | 8'h01;
        bus(1'b1, rst_pkg::WAKE_OFS, {24'h0, mask}, q);
        bus(1'b1, rst_pkg::OSC_OFS, 32'h0, q);
        bus(1'b1, rst_pkg::PWR_OFS, 32'h10, q);
        bus(1'b0, rst_pkg::CAUSE_OFS, 32'h0, q);
        chk("ipo off", 32'h0, 32'({ipoe, ipos}));
        pulse(2, 1);
        repeat (3) @(posedge clk);
        chk("stop mode", 32'h1, 32'(stopm));
        chk("brownout off in stop", 32'h0, 32'(boa));
        gpio <= 8'h01;
        wait_sig(0, 1'b1, 20);
        chk("no sys reset", 32'h0, 32'(sysr));
        wait_sig(0, 1'b0, 200);
        chk("ipo on", 32'h3, 32'({ipoe, ipos}));
        bus(1'b0, rst_pkg::WAKE_OFS, 32'h0, q);
        chk("wake kept", {24'h0, mask}, q);
        bus(1'b0, rst_pkg::CAUSE_OFS, 32'h0, q);
        chk("cause stop", 32'h40, q);
        $display("stop recovery test done");
        pulse(2, 1);
        repeat (3) @(posedge clk);
        pulse(4, 1);
        wait_sig(0, 1'b1, 20);
        chk("no sys reset tmr", 32'h0, 32'(sysr));
        wait_sig(0, 1'b0, 200);
        bus(1'b0, rst_pkg::CAUSE_OFS, 32'h0, q);
        chk("cause timer stop", 32'h40, q);
        $display("timer wake test done");
        pulse(2, 1);
        repeat (3) @(posedge clk);
        pulse(3, 8);
        wait_sig(1, 1'b1, 20);
        wait_sig(0, 1'b0, 1000);
        $display("stop debug test done");
        print_verdict();
    end
endmodule
`default_nettype wire

// File: rst_pkg.sv
// Constants, register map and bus carrier for the reset and stop recovery controller
package rst_pkg;
    // Classic Wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [3:0]  sel;
        logic [7:0]  adr;
        logic [31:0] dat;
    } wb_req_t;

    typedef enum {ST_RUN, ST_STOP, ST_START, ST_SYS, ST_SMR} seq_state_t;

    // Register byte offsets
    localparam logic [7:0] CAUSE_OFS = 8'h00;
    localparam logic [7:0] PWR_OFS   = 8'h04;
    localparam logic [7:0] DBGC_OFS  = 8'h08;
    localparam logic [7:0] WDC_OFS   = 8'h0C;
    localparam logic [7:0] OSC_OFS   = 8'h10;
    localparam logic [7:0] WAKE_OFS  = 8'h14;

    // Field positions
    localparam int CAUSE_POB  = 7;
    localparam int CAUSE_STOP = 6;
    localparam int CAUSE_WDT  = 5;
    localparam int CAUSE_EXT  = 4;
    localparam int CAUSE_LVD  = 0;
    localparam int PWR_BO_OFF = 4;
    localparam int PWR_IND    = 0;
    localparam int DBGC_REQ   = 0;
    localparam int WDC_POR    = 7;
    localparam int OSC_EN     = 0;
    localparam int OSC_SEL    = 1;

    // Reset values
    localparam logic [7:0] CAUSE_RST = 8'h80;
    localparam logic [7:0] PWR_RST   = 8'h00;
    localparam logic [7:0] OSC_RST   = 8'h03;
    localparam logic [7:0] WAKE_RST  = 8'h00;

    // Timing
    localparam int         CLK_NS       = 50;
    localparam int         IPO_START_NS = 4000;
    localparam int         IPO_START_CYC = (IPO_START_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [6:0] START_LAST   = 7'(IPO_START_CYC - 1);
    localparam logic [6:0] SYS_HOLD_IPO = 7'h44;
    localparam logic [6:0] SMR_HOLD_IPO = 7'h04;
    localparam logic [1:0] IPO_DIV_LAST = 2'h1;
    localparam logic [1:0] PIN_MIN_LOW  = 2'h3;
    localparam logic [15:0] VEC_ADDR    = 16'h0002;

    // Synchroniser lanes
    localparam int          SYNC_W   = 13;
    localparam int          S_RSTPIN = 8;
    localparam int          S_DBGPIN = 9;
    localparam int          S_POR_N  = 10;
    localparam int          S_BOLOW  = 11;
    localparam int          S_LVD    = 12;
    localparam logic [12:0] SYNC_RST = 13'h0700;
endpackage
